// ===== design/sfp_pkg.sv
// Purpose: shared constants for the serial flash mode and protection front end
// Assumes: 24-bit array addresses, 8-bit opcodes
// Notes: timing is counted in system clock cycles
package sfp_pkg;
	localparam int ADDR_W = 24;
	localparam logic [7:0] OP_SET_WRITE_LATCH_CMD_SET = 8'h06;
	localparam logic [7:0] OP_SET_WRITE_LATCH_CMD_CLR = 8'h04;
	localparam logic [7:0] OP_STATUS_WR = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_ERASE_ALL = 8'hc7;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_QUAD_WORD = 8'he7;
	localparam logic [7:0] OP_QPI_ENTER = 8'h38;
	localparam logic [7:0] OP_QPI_EXIT = 8'hff;
	localparam logic [7:0] OP_RESET_EN = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_DPD_EXIT = 8'hab;
	localparam logic [7:0] OP_DPD_ENTER = 8'hb9;
	localparam logic [2:0] CNT_BITS_W = 3'h7;
	localparam logic [23:0] PROT_HALF = 24'h800000;
	localparam logic [23:0] PROT_SIXTYFOURTH = 24'h040000;
	localparam logic [23:0] PROT_SECTOR = 24'h001000;
	typedef enum logic [1:0]
	{
		SFP_W1 = 2'b00,
		SFP_W2 = 2'b01,
		SFP_W4 = 2'b10
	} sfp_width_t;
endpackage

// ===== design/sfp_front.sv
// Purpose: serial flash front end: line width, four-line command mode, pause,
//          write latch, protect bits and protected-range decode
// Assumes: serial clock, select and pause pins sampled by clk_in (100 MHz)
// Notes: opcode decode only; address and data phases are left to the core,
//        which feeds the target address and reports completion
`timescale 1ns/1ps
`default_nettype none
module sfp_front
(
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      sclk_in,
	input  wire logic                      cs_n_in,
	input  wire logic [3:0]                io_in,
	output logic [3:0]                     io_out,
	output logic [3:0]                     io_oe_out,
	input  wire logic                      quad_enable_bit_in,
	input  wire logic [sfp_pkg::ADDR_W-1:0] target_addr_in,
	input  wire logic                      op_done_in,
	input  wire logic [3:0]                tx_nibble_in,
	input  wire logic                      tx_active_in,
	input  wire logic [4:0]                new_protect_in,
	input  wire logic [1:0]                new_lock_in,
	input  wire logic                      complement_bit_in,
	output logic [7:0]                     opcode_out,
	output logic                           opcode_valid_out,
	output logic                           four_line_command_mode_out,
	output logic                           write_latch_flag_out,
	output logic [4:0]                     block_protect_bits_out,
	output logic [1:0]                     status_lock_bits_out,
	output logic [1:0]                     lane_width_out,
	output logic                           paused_out,
	output logic                           powered_down_out,
	output logic                           write_go_out,
	output logic                           range_hit_out
);
	import sfp_pkg::*;

	logic [1:0] sclk_s, cs_s, hold_s, wp_s;
	logic [3:0] io_s1, io_s2;
	logic sclk_d, hold_d;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sclk_s <= 2'h0;
			cs_s <= 2'h3;
			hold_s <= 2'h3;
			wp_s <= 2'h3;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
			sclk_d <= 1'b0;
			hold_d <= 1'b1;
		end
		else
		begin
			sclk_s <= {sclk_s[0], sclk_in};
			cs_s <= {cs_s[0], cs_n_in};
			hold_s <= {hold_s[0], io_in[3]};
			wp_s <= {wp_s[0], io_in[2]};
			io_s1 <= io_in;
			io_s2 <= io_s1;
			sclk_d <= sclk_s[1];
			hold_d <= hold_s[1];
		end
	end

	wire sclk = sclk_s[1];
	wire cs_low = !cs_s[1];
	wire rise = sclk && !sclk_d;
	wire fall = !sclk && sclk_d;
	wire wide = (lane_width_out != 2'(SFP_W1)) || four_line_command_mode_out;
	// Pins 2 and 3 only act as protect and pause while single-lane
	wire hold_pin = wide ? 1'b1 : hold_s[1];
	wire wp_low = !wide && !wp_s[1];

	logic pause_req;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pause_req <= 1'b0;
		else if (!cs_low)
			pause_req <= 1'b0;
		else if (!hold_pin && hold_d)
			pause_req <= 1'b1;
		else if (hold_pin && !hold_d)
			pause_req <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			paused_out <= 1'b0;
		else if (!cs_low)
			paused_out <= 1'b0;
		else if (!sclk)
			paused_out <= pause_req;
	end

	wire shift_en = cs_low && !paused_out && rise;
	wire out_en = cs_low && !paused_out && fall;

	logic [7:0] shreg;
	logic [2:0] bitcnt;
	logic       op_taken;
	wire  [7:0] next_shreg = four_line_command_mode_out ? {shreg[3:0], io_s2}
	                                                    : {shreg[6:0], io_s2[0]};
	wire        byte_end = four_line_command_mode_out ? (bitcnt == 3'h1)
	                                                  : (bitcnt == CNT_BITS_W);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			shreg <= 8'h00;
			bitcnt <= 3'h0;
			op_taken <= 1'b0;
		end
		else if (!cs_low)
		begin
			bitcnt <= 3'h0;
			op_taken <= 1'b0;
		end
		else if (shift_en && !op_taken)
		begin
			shreg <= next_shreg;
			bitcnt <= byte_end ? 3'h0 : 3'(bitcnt + 3'h1);
			op_taken <= byte_end;
		end
	end

	wire op_strobe = shift_en && !op_taken && byte_end;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			opcode_out <= 8'h00;
			opcode_valid_out <= 1'b0;
		end
		else
		begin
			opcode_valid_out <= op_strobe && (!powered_down_out || next_shreg == OP_DPD_EXIT);
			if (op_strobe)
				opcode_out <= next_shreg;
		end
	end

	wire [7:0] op = opcode_out;
	wire ov = opcode_valid_out;
	wire is_quad = op == OP_QUAD_OUT || op == OP_QUAD_IO || op == OP_QUAD_WORD
		|| op == OP_QUAD_PROG;
	wire is_dual = op == OP_DUAL_OUT || op == OP_DUAL_IO;
	wire is_write = op == OP_STATUS_WR || op == OP_PAGE_PROG || op == OP_QUAD_PROG
		|| op == OP_ERASE_4K || op == OP_ERASE_32K || op == OP_ERASE_64K
		|| op == OP_ERASE_ALL || op == OP_SEC_ERASE || op == OP_SEC_PROG;
	wire is_array = is_write && op != OP_STATUS_WR && op != OP_SEC_ERASE
		&& op != OP_SEC_PROG;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			powered_down_out <= 1'b0;
		else if (ov && op == OP_DPD_ENTER)
			powered_down_out <= 1'b1;
		else if (ov && op == OP_DPD_EXIT)
			powered_down_out <= 1'b0;
	end

	logic reset_armed;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reset_armed <= 1'b0;
		else if (ov)
			reset_armed <= op == OP_RESET_EN;
	end

	// enter/exit; one flag holds both modes; reset to normal
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			four_line_command_mode_out <= 1'b0;
		else if (ov && op == OP_RESET && reset_armed)
			four_line_command_mode_out <= 1'b0;
		else if (ov && op == OP_QPI_ENTER && !four_line_command_mode_out)
			four_line_command_mode_out <= 1'b1;
		else if (ov && op == OP_QPI_EXIT && four_line_command_mode_out)
			four_line_command_mode_out <= 1'b0;
	end

	// dual lanes; quad lanes; gated by quad enable
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			lane_width_out <= 2'(SFP_W1);
		else if (!cs_low)
			lane_width_out <= 2'(SFP_W1);
		else if (ov && is_quad && quad_enable_bit_in)
			lane_width_out <= 2'(SFP_W4);
		else if (ov && is_dual)
			lane_width_out <= 2'(SFP_W2);
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			write_latch_flag_out <= 1'b0;
		else if (ov && op == OP_SET_WRITE_LATCH_CMD_SET)
			write_latch_flag_out <= 1'b1;
		else if ((ov && op == OP_SET_WRITE_LATCH_CMD_CLR) || op_done_in)
			write_latch_flag_out <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			block_protect_bits_out <= 5'h00;
			status_lock_bits_out <= 2'h0;
		end
		else if (write_go_out && op == OP_STATUS_WR && !wp_low)
		begin
			block_protect_bits_out <= new_protect_in;
			status_lock_bits_out <= new_lock_in;
		end
	end

	logic [ADDR_W-1:0] lo, hi;
	logic none_hit;
	logic [2:0] lb;
	always_comb
	begin
		lb = block_protect_bits_out[2:0];
		lo = '0;
		hi = '1;
		none_hit = 1'b0;
		if (lb == 3'h0)
			none_hit = 1'b1;
		else if (lb != 3'h7)
			unique case (block_protect_bits_out[4:3])
				2'h0: lo = ~((PROT_HALF >> (3'h6 - lb)) - 24'h000001);
				2'h1: hi = (PROT_SIXTYFOURTH << (lb - 3'h1)) - 24'h000001;
				2'h2: lo = 24'hffffff - ((PROT_SECTOR << ((lb > 3'h4) ? 3'h3
					: lb - 3'h1)) - 24'h000001);
				2'h3: hi = (PROT_SECTOR << ((lb > 3'h4) ? 3'h3 : lb - 3'h1)) - 24'h000001;
			endcase
	end
	wire in_range = !none_hit && target_addr_in >= lo && target_addr_in <= hi;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			range_hit_out <= 1'b0;
		else
			range_hit_out <= in_range ^ complement_bit_in;
	end

	// latch gate; protected array writes dropped
	always_comb
		write_go_out = ov && is_write && write_latch_flag_out
			&& !(is_array && range_hit_out);

	// only serial side paused; falling edge shift
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			io_out <= 4'h0;
			io_oe_out <= 4'h0;
		end
		else if (!cs_low || paused_out || !tx_active_in)
			io_oe_out <= 4'h0;
		else if (out_en)
		begin
			io_out <= tx_nibble_in;
			unique case (lane_width_out)
				2'(SFP_W4): io_oe_out <= 4'hf;
				2'(SFP_W2): io_oe_out <= 4'h3;
				default: io_oe_out <= four_line_command_mode_out ? 4'hf : 4'h2;
			endcase
		end
	end

	pause_float_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		paused_out |=> io_oe_out == 4'h0)
		else $error("output driven while paused");
	latch_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		write_go_out |-> write_latch_flag_out)
		else $error("write started without latch");
	wp_freeze_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wp_low |=> $stable(block_protect_bits_out) && $stable(status_lock_bits_out))
		else $error("protect bits changed");
	quad_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!quad_enable_bit_in |=> lane_width_out != 2'(SFP_W4) || $past(lane_width_out) == 2'(SFP_W4))
		else $error("quad without enable");
	latch_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ov && op == OP_SET_WRITE_LATCH_CMD_SET |=> write_latch_flag_out)
		else $error("latch not set");
	dpd_filter_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ov && $past(powered_down_out) |-> op == OP_DPD_EXIT)
		else $error("command accepted in power-down");
	prot_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ov && is_array && range_hit_out |-> !write_go_out)
		else $error("protected write started");
	cs_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!cs_low |=> !paused_out && bitcnt == 3'h0)
		else $error("serial logic not reset");
endmodule
`default_nettype wire

// ===== tb/sfp_host_model.sv
// Purpose: host serial controller model on the flash pins
// Assumes: mode 0, serial clock period 160 ns
// Notes: can pause in mid-frame on request
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model
(
	input  wire logic       protect_n_in,
	input  wire logic       hold_mid_in,
	output logic            sclk_out,
	output logic            cs_n_out,
	output logic [3:0]      io_out
);
	logic       quad;
	logic       pause_n;
	logic [3:0] dat;
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		quad = 1'b0;
		pause_n = 1'b1;
		dat = 4'h0;
	end
	// Protect and pause share lanes 2 and 3 outside four-lane frames
	assign io_out = quad ? dat : {pause_n, protect_n_in, dat[1:0]};
	task automatic send(input logic [7:0] op, input logic q);
		int n;
		n = q ? 2 : 8;
		quad = q;
		cs_n_out = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			if (q)
				dat = op[7-4*i -: 4];
			else
				dat[0] = op[7-i];
			#80;
			sclk_out = 1'b1;
			#80;
			sclk_out = 1'b0;
			if (hold_mid_in && i == 3)
			begin
				// pause with clock low, select kept low
				pause_n = 1'b0;
				#160;
				dat = ~dat;
				repeat (2)
				begin
					#80 sclk_out = 1'b1;
					#80 sclk_out = 1'b0;
				end
				pause_n = 1'b1;
				#160;
			end
		end
		#80;
		cs_n_out = 1'b1;
		quad = 1'b0;
		// Released lines show the inverse, not a held value
		dat = ~dat;
		#320;
	endtask
endmodule
`default_nettype wire

// ===== tb/sfp_front_tb.sv
// Purpose: self-checking bench for the flash front end
// Assumes: host model on the serial pins
// Notes: random addresses from a fixed seed plus range corners
`timescale 1ns/1ps
`default_nettype none
module sfp_front_tb;
	import sfp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        qe = 1'b0;
	logic        done = 1'b0;
	logic        cmpb = 1'b0;
	logic        prot_n = 1'b1;
	logic        saw_p = 1'b0;
	logic        txa = 1'b0;
	logic        hmid = 1'b0;
	logic        sclk, cs_n, go, vld, mode, write_latch_flag, paused, pd, hit;
	logic [3:0]  hio, pin, dout, oe;
	logic [3:0]  txn = 4'h0;
	logic [23:0] tgt = 24'h0;
	logic [31:0] r;
	logic [4:0]  np = 5'h0;
	logic [4:0]  bp;
	logic [1:0]  nl = 2'h0;
	logic [1:0]  lk, lane;
	logic [1:0]  lane_s = 2'h0;
	logic [3:0]  oe_s = 4'h0;
	logic [7:0]  op;
	int          failures = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          go_cnt = 0;
	int          vld_cnt = 0;
	int          n;
	int          seed = 32'h4bd5;
	logic [23:0] cor [14] = '{24'h0, 24'h000fff, 24'h001000, 24'h007fff, 24'h008000,
		24'h03ffff, 24'h040000, 24'hfbffff, 24'hfc0000, 24'hff7fff, 24'hff8000,
		24'hffefff, 24'hfff000, 24'hffffff};
	logic [7:0]  wops [9] = '{OP_SET_WRITE_LATCH_CMD_CLR, OP_STATUS_WR, OP_PAGE_PROG, OP_ERASE_4K,
		OP_ERASE_32K, OP_ERASE_64K, OP_ERASE_ALL, OP_SEC_ERASE, OP_SEC_PROG};
	logic [10:0] lt [7] = '{{1'b0, SFP_W2, OP_DUAL_OUT}, {1'b0, SFP_W2, OP_DUAL_IO},
		{1'b0, SFP_W1, OP_QUAD_OUT}, {1'b1, SFP_W4, OP_QUAD_OUT}, {1'b1, SFP_W4, OP_QUAD_IO},
		{1'b1, SFP_W4, OP_QUAD_WORD}, {1'b1, SFP_W4, OP_QUAD_PROG}};
	always #5 clk = ~clk;
	assign pin = (oe & dout) | (~oe & hio);
	sfp_host_model host (.protect_n_in(prot_n), .hold_mid_in(hmid), .sclk_out(sclk),
		.cs_n_out(cs_n), .io_out(hio));
	sfp_front uut (.clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
		.io_in(pin), .io_out(dout), .io_oe_out(oe), .quad_enable_bit_in(qe),
		.target_addr_in(tgt), .op_done_in(done), .tx_nibble_in(txn), .tx_active_in(txa),
		.new_protect_in(np), .new_lock_in(nl), .complement_bit_in(cmpb), .opcode_out(op),
		.opcode_valid_out(vld), .four_line_command_mode_out(mode),
		.write_latch_flag_out(write_latch_flag), .block_protect_bits_out(bp), .status_lock_bits_out(lk),
		.lane_width_out(lane), .paused_out(paused), .powered_down_out(pd),
		.write_go_out(go), .range_hit_out(hit));
	always @(posedge clk)
	begin
		cycles++;
		txn <= txa ? 4'ha : 4'($random(seed));
		if (go === 1'b1)
			go_cnt++;
		if (vld === 1'b1)
			vld_cnt++;
		if (oe !== 4'h0)
			oe_s = oe;
		if (paused === 1'b1)
			saw_p = 1'b1;
		if (lane !== 2'h0)
			lane_s = lane;
		if (cycles == 90000)
		begin
			failures++;
			summarize();
		end
	end
	function automatic logic exp_hit(input logic [4:0] b, input logic c, input logic [23:0] a);
		int sz;
		int ks;
		logic h;
		sz = 32'h40000 << (b[2:0] - 3'h1);
		ks = b[2] ? 32'h8000 : 32'h1000 << (b[2:0] - 3'h1);
		case (b[4:3])
			2'b00: h = int'(a) >= 32'h1000000 - sz;
			2'b01: h = int'(a) < sz;
			2'b10: h = int'(a) >= 32'h1000000 - ks;
			default: h = int'(a) < ks;
		endcase
		if (b[2:0] == 3'h0)
			h = 1'b0;
		if (b[2:0] == 3'h7)
			h = 1'b1;
		return h ^ c;
	endfunction
	task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] o, input logic q);
		host.send(o, q);
		tick(12);
	endtask
	task automatic done_pulse;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(3);
	endtask
	task automatic set_prot(input logic [4:0] v, input logic [1:0] l);
		np = v;
		nl = l;
		cmd(OP_SET_WRITE_LATCH_CMD_SET, 1'b0);
		cmd(OP_STATUS_WR, 1'b0);
		done_pulse();
	endtask
	task automatic summarize;
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		tick(20);
		rst_n = 1'b1;
		tick(5);
		check("mode at reset", 0, mode);
		foreach (wops[k])
		begin
			cmd(OP_SET_WRITE_LATCH_CMD_SET, 1'b0);
			check("latch set", 1, write_latch_flag);
			n = go_cnt;
			cmd(wops[k], 1'b0);
			done_pulse();
			check("write accepted", k > 0, go_cnt - n);
			check("latch cleared", 0, write_latch_flag);
			cmd(OP_PAGE_PROG, 1'b0);
			check("no latch no write", k > 0, go_cnt - n);
		end
		foreach (lt[k])
		begin
			qe = lt[k][10];
			lane_s = 2'h0;
			cmd(lt[k][7:0], 1'b0);
			check("lanes", lt[k][9:8], lane_s);
		end
		for (int b = 0; b < 32; b++)
		begin
			set_prot(5'(b), 2'h0);
			check("protect bits", b, bp);
			for (int j = 0; j < 20; j++)
			begin
				r = $random(seed);
				tgt = j < 14 ? cor[j] : r[23:0];
				cmpb = r[31];
				tick(4);
				check("range", exp_hit(5'(b), cmpb, tgt), hit);
			end
		end
		cmpb = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			r = $random(seed);
			set_prot(k ? r[28:24] : 5'h07, 2'h0);
			tgt = r[23:0];
			cmd(OP_SET_WRITE_LATCH_CMD_SET, 1'b0);
			n = go_cnt;
			cmd(OP_ERASE_4K, 1'b0);
			check("protected write", !exp_hit(np, 1'b0, tgt), go_cnt - n);
			done_pulse();
		end
		set_prot(5'h05, 2'h0);
		prot_n = 1'b0;
		set_prot(5'h1f, 2'h3);
		check("frozen protect", 5'h05, bp);
		check("frozen lock", 0, lk);
		prot_n = 1'b1;
		cmd(OP_QPI_ENTER, 1'b0);
		check("four line on", 1, mode);
		cmd(OP_SET_WRITE_LATCH_CMD_SET, 1'b1);
		check("nibble opcode", 1, write_latch_flag);
		check("opcode value", OP_SET_WRITE_LATCH_CMD_SET, op);
		cmd(OP_QPI_EXIT, 1'b1);
		check("four line off", 0, mode);
		cmd(OP_QPI_ENTER, 1'b0);
		cmd(OP_RESET_EN, 1'b1);
		cmd(OP_RESET, 1'b1);
		check("soft reset", 0, mode);
		cmd(OP_SET_WRITE_LATCH_CMD_CLR, 1'b0);
		cmd(OP_DPD_ENTER, 1'b0);
		check("power down", 1, pd);
		n = vld_cnt;
		cmd(OP_SET_WRITE_LATCH_CMD_SET, 1'b0);
		check("ignored in power down", 0, write_latch_flag);
		check("filtered strobe", n, vld_cnt);
		cmd(OP_DPD_EXIT, 1'b0);
		check("power up", 0, pd);
		hmid = 1'b1;
		txa = 1'b1;
		cmd(OP_SET_WRITE_LATCH_CMD_SET, 1'b0);
		hmid = 1'b0;
		txa = 1'b0;
		check("output lanes", 4'h2, oe_s);
		check("shifted nibble", 4'ha, dout);
		check("pause seen", 1, saw_p);
		check("pause ended", 0, paused);
		check("pause ignores clock", 1, write_latch_flag);
		summarize();
	end
endmodule
`default_nettype wire
